// ### io_register_space_bit_access.sv
`timescale 1ns/1ps
module io_register_space_bit_access (
    input wire logic clk,
    input wire logic arst_n,
    input io_space_pkg::core_req_t core_req,
    output io_space_pkg::core_rsp_t core_rsp,
    input io_space_pkg::periph_in_t periph_in,
    output io_space_pkg::periph_cfg_t periph_cfg,
    input wire logic [7:0] port_a_pins,
    input wire logic [7:0] port_b_pins,
    output logic [7:0] port_a_o,
    output logic [7:0] port_a_oe,
    output logic [7:0] port_b_o,
    output logic [7:0] port_b_oe
);
    import io_space_pkg::*;

    function automatic logic [7:0] rw_mask(input logic [5:0] a);
        case (a)
            ADDR_POWER_REDUCTION: rw_mask = RW_POWER_REDUCTION;
            ADDR_INPUT_DISABLE: rw_mask = RW_INPUT_DISABLE;
            ADDR_CONV_CONTROL: rw_mask = RW_CONV_CONTROL;
            ADDR_CONV_CHANNEL: rw_mask = RW_CONV_CHANNEL;
            ADDR_COMPARATOR: rw_mask = RW_COMPARATOR;
            ADDR_TIMER1_MASK: rw_mask = RW_TIMER1_MASK;
            ADDR_SERIAL_STATUS: rw_mask = RW_SERIAL_STATUS;
            ADDR_NV_CONTROL: rw_mask = RW_NV_CONTROL;
            ADDR_NV_LOCATION: rw_mask = RW_NV_LOCATION;
            ADDR_WATCHDOG: rw_mask = RW_WATCHDOG;
            ADDR_SERIAL_CONTROL, ADDR_SERIAL_DATA, ADDR_PIN_MASK_LOW,
            ADDR_SCRATCH_0, ADDR_SCRATCH_1, ADDR_SCRATCH_2,
            ADDR_PORT_B_DIRECTION, ADDR_PORT_B_OUTPUT,
            ADDR_PORT_A_DIRECTION, ADDR_PORT_A_OUTPUT,
            ADDR_NV_VALUE, ADDR_PIN_MASK_HIGH: rw_mask = FULL_BYTE;
            default: rw_mask = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] w1c_mask(input logic [5:0] a);
        case (a)
            ADDR_CONV_CONTROL: w1c_mask = W1C_CONV_CONTROL;
            ADDR_COMPARATOR: w1c_mask = W1C_COMPARATOR;
            ADDR_TIMER1_FLAGS: w1c_mask = W1C_TIMER1;
            ADDR_SERIAL_STATUS: w1c_mask = W1C_SERIAL_STATUS;
            ADDR_WATCHDOG: w1c_mask = W1C_WATCHDOG;
            default: w1c_mask = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] ro_mask(input logic [5:0] a);
        case (a)
            ADDR_CONV_LOW, ADDR_CONV_HIGH, ADDR_SERIAL_BUFFER,
            ADDR_PORT_B_INPUT, ADDR_PORT_A_INPUT: ro_mask = FULL_BYTE;
            ADDR_COMPARATOR: ro_mask = RO_COMPARATOR;
            ADDR_SERIAL_STATUS: ro_mask = RO_SERIAL_STATUS;
            default: ro_mask = 8'h00;
        endcase
    endfunction

    // flag events from the peripherals, per register
    function automatic logic [7:0] hw_set(input logic [5:0] a, input periph_in_t p);
        case (a)
            ADDR_CONV_CONTROL: hw_set = W1C_CONV_CONTROL & {8{p.conv_done}};
            ADDR_COMPARATOR: hw_set = W1C_COMPARATOR & {8{p.comp_event}};
            ADDR_TIMER1_FLAGS: hw_set = W1C_TIMER1 & {5'h00, p.timer1_set};
            ADDR_SERIAL_STATUS: hw_set = W1C_SERIAL_STATUS & {p.serial_set, 5'h00};
            ADDR_WATCHDOG: hw_set = W1C_WATCHDOG & {8{p.wdog_event}};
            default: hw_set = 8'h00;
        endcase
    endfunction

    logic [7:0] regs [0:MAP_LAST];
    logic [7:0] next_regs [0:MAP_LAST];
    logic [7:0] a_s1, a_s2, a_s3, a_hold;
    logic [7:0] b_s1, b_s2, b_s3, b_hold;
    logic [7:0] next_a_hold, next_b_hold;
    core_rsp_t next_rsp;
    logic [6:0] io_addr;
    logic [5:0] idx;
    logic in_map, bit_ok, bit_op, test_op, do_wr;
    logic [7:0] be, wd, ro_val, rd_val, cur;

    // pins: three stages, a bit moves once stages two and three agree
    always_comb begin
        next_a_hold = (~(a_s2 ^ a_s3) & a_s3) | ((a_s2 ^ a_s3) & a_hold);
        next_b_hold = (~(b_s2 ^ b_s3) & b_s3) | ((b_s2 ^ b_s3) & b_hold);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            a_s1 <= 8'h00;
            a_s2 <= 8'h00;
            a_s3 <= 8'h00;
            a_hold <= 8'h00;
            b_s1 <= 8'h00;
            b_s2 <= 8'h00;
            b_s3 <= 8'h00;
            b_hold <= 8'h00;
        end else begin
            a_s1 <= port_a_pins;
            a_s2 <= a_s1;
            a_s3 <= a_s2;
            a_hold <= next_a_hold;
            b_s1 <= port_b_pins;
            b_s2 <= b_s1;
            b_s3 <= b_s2;
            b_hold <= next_b_hold;
        end
    end

    always_comb begin
        io_addr = core_req.data_space ? core_req.addr - DATA_SPACE_OFFSET : core_req.addr;
        // data-space addresses below 0x20 wrap high and decode unmapped
        in_map = (io_addr <= {1'b0, MAP_LAST}) &&
                 ((rw_mask(io_addr[5:0]) | w1c_mask(io_addr[5:0]) |
                   ro_mask(io_addr[5:0])) != 8'h00);
        idx = in_map ? io_addr[5:0] : 6'h00;
        bit_ok = io_addr <= BIT_RANGE_TOP;
        bit_op = core_req.op == OP_SET_SINGLE_IO_BIT || core_req.op == OP_CLEAR_SINGLE_IO_BIT;
        test_op = core_req.op == OP_SKIP_IF_IO_BIT_ONE || core_req.op == OP_SKIP_IF_IO_BIT_ZERO;
        do_wr = core_req.valid && in_map &&
                (core_req.op == OP_WRITE || (bit_op && bit_ok));
        // one bit lane for bit operations
        be = (core_req.op == OP_WRITE) ? FULL_BYTE : 8'h01 << core_req.bit_sel;
        wd = (core_req.op == OP_WRITE) ? core_req.wdata :
             ((core_req.op == OP_SET_SINGLE_IO_BIT) ? FULL_BYTE : 8'h00);
        case (idx)
            ADDR_CONV_LOW: ro_val = periph_in.conv_low;
            ADDR_CONV_HIGH: ro_val = periph_in.conv_high;
            ADDR_SERIAL_BUFFER: ro_val = periph_in.serial_buffer;
            ADDR_PORT_A_INPUT: ro_val = a_hold;
            ADDR_PORT_B_INPUT: ro_val = b_hold;
            ADDR_COMPARATOR: ro_val = RO_COMPARATOR & {8{periph_in.comp_out}};
            ADDR_SERIAL_STATUS: ro_val = RO_SERIAL_STATUS & {8{periph_in.serial_collision}};
            default: ro_val = 8'h00;
        endcase
        // reserved bits are never stored and read zero
        rd_val = in_map ? ((regs[idx] & (rw_mask(idx) | w1c_mask(idx))) | ro_val) : 8'h00;
    end

    // one pass per register keeps write and event merge together
    always_comb begin
        cur = 8'h00;
        for (int i = 0; i <= int'(MAP_LAST); i++) begin
            cur = regs[i];
            if (do_wr && idx == 6'(i)) begin
                // set or clear of a read-write bit lands straight in the register
                cur = (cur & ~(rw_mask(idx) & be)) | (wd & rw_mask(idx) & be);
                // ones clear flags, zeros leave them
                cur = cur & ~(wd & w1c_mask(idx) & be);
            end
            // event in the clearing cycle is kept: set wins
            next_regs[i] = (cur & (rw_mask(6'(i)) | w1c_mask(6'(i)))) | hw_set(6'(i), periph_in);
        end
    end

    always_comb begin
        next_rsp.done = core_req.valid;
        next_rsp.rdata = (core_req.valid && core_req.op == OP_READ) ? rd_val : 8'h00;
        // skip on the tested bit value
        next_rsp.skip = core_req.valid && test_op && bit_ok && in_map &&
                        (rd_val[core_req.bit_sel] == (core_req.op == OP_SKIP_IF_IO_BIT_ONE));
        // bit work above the low range is refused
        next_rsp.refused = core_req.valid &&
                           (((bit_op || test_op) && !bit_ok) ||
                            (core_req.op == OP_WRITE && !in_map));
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i <= int'(MAP_LAST); i++) begin
                regs[i] <= REG_RESET;
            end
            core_rsp <= '0;
        end else begin
            for (int i = 0; i <= int'(MAP_LAST); i++) begin
                regs[i] <= next_regs[i];
            end
            core_rsp <= next_rsp;
        end
    end

    assign periph_cfg.power_reduction = regs[ADDR_POWER_REDUCTION];
    assign periph_cfg.digital_input_disable = regs[ADDR_INPUT_DISABLE];
    assign periph_cfg.converter_control_status_a = regs[ADDR_CONV_CONTROL];
    assign periph_cfg.converter_channel_select = regs[ADDR_CONV_CHANNEL];
    assign periph_cfg.comparator_control_status = regs[ADDR_COMPARATOR];
    assign periph_cfg.timer1_flags = regs[ADDR_TIMER1_FLAGS];
    assign periph_cfg.timer1_irq_mask = regs[ADDR_TIMER1_MASK];
    assign periph_cfg.serial_if_control = regs[ADDR_SERIAL_CONTROL];
    assign periph_cfg.serial_if_status = regs[ADDR_SERIAL_STATUS];
    assign periph_cfg.serial_if_shift_data = regs[ADDR_SERIAL_DATA];
    assign periph_cfg.pin_change_mask_low = regs[ADDR_PIN_MASK_LOW];
    assign periph_cfg.pin_change_mask_high = regs[ADDR_PIN_MASK_HIGH];
    assign periph_cfg.nv_data_control = regs[ADDR_NV_CONTROL];
    assign periph_cfg.nv_data_value = regs[ADDR_NV_VALUE];
    assign periph_cfg.nv_data_location = regs[ADDR_NV_LOCATION];
    assign periph_cfg.watchdog_control_status = regs[ADDR_WATCHDOG];
    // output enable follows direction; output value is the output register, not gated by direction
    assign port_a_o = regs[ADDR_PORT_A_OUTPUT];
    assign port_a_oe = regs[ADDR_PORT_A_DIRECTION];
    assign port_b_o = regs[ADDR_PORT_B_OUTPUT];
    assign port_b_oe = regs[ADDR_PORT_B_DIRECTION];

    // helpers seen only by the checks below
    logic [5:0] h_idx;
    logic [7:0] h_prev, h_be, h_hw, h_rd, sel_now;
    logic h_zero;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            h_idx <= 6'h00;
            h_prev <= 8'h00;
            h_be <= 8'h00;
            h_hw <= 8'h00;
            h_rd <= 8'h00;
            h_zero <= 1'b0;
        end else begin
            h_idx <= idx;
            h_prev <= regs[idx];
            h_be <= be;
            h_hw <= hw_set(idx, periph_in);
            h_rd <= rd_val;
            h_zero <= core_req.op == OP_SKIP_IF_IO_BIT_ZERO;
        end
    end

    // current value of the register the checked request hit, one cycle on
    assign sel_now = regs[h_idx];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    AST_SET_BIT: assert property (
        core_req.valid && core_req.op == OP_SET_SINGLE_IO_BIT && bit_ok && in_map
        |=> (sel_now & rw_mask(h_idx) & h_be) == (rw_mask(h_idx) & h_be))
        else $error("set bit did not land");
    AST_CLEAR_BIT: assert property (
        core_req.valid && core_req.op == OP_CLEAR_SINGLE_IO_BIT && bit_ok && in_map
        |=> (sel_now & rw_mask(h_idx) & h_be) == 8'h00)
        else $error("clear bit did not land");
    AST_SKIP_MATCH: assert property (
        core_req.valid && test_op && bit_ok && in_map
        |=> core_rsp.done && core_rsp.skip == (((h_rd & h_be) != 8'h00) ^ h_zero))
        else $error("skip answer wrong");
    AST_NO_HIGH_TEST: assert property (
        core_req.valid && test_op && !bit_ok |=> !core_rsp.skip && core_rsp.refused)
        else $error("test above low range accepted");
    AST_W1C_ZERO_KEEPS: assert property (
        core_req.valid && core_req.op == OP_WRITE && in_map &&
        (core_req.wdata & w1c_mask(idx)) == 8'h00
        |=> (h_prev & ~sel_now & w1c_mask(h_idx)) == 8'h00)
        else $error("zero write cleared a flag");
    AST_W1C_ONE_CLEARS: assert property (
        core_req.valid && core_req.op == OP_WRITE && in_map && w1c_mask(idx) != 8'h00 &&
        (core_req.wdata & w1c_mask(idx)) == w1c_mask(idx) && hw_set(idx, periph_in) == 8'h00
        |=> (sel_now & w1c_mask(h_idx)) == 8'h00)
        else $error("one write left a flag");
    AST_BIT_ONLY: assert property (
        core_req.valid && bit_op && bit_ok && in_map
        |=> ((h_prev ^ sel_now) & ~h_be & ~h_hw) == 8'h00)
        else $error("bit op touched other bits");
    AST_HIGH_BIT_REFUSED: assert property (
        core_req.valid && bit_op && !bit_ok && in_map
        |=> core_rsp.refused && ((h_prev ^ sel_now) & ~h_hw) == 8'h00)
        else $error("bit op above low range took effect");
    AST_DATA_ALIAS: assert property (
        core_req.valid && core_req.op == OP_WRITE && core_req.data_space &&
        core_req.addr == DATA_SPACE_OFFSET + {1'b0, ADDR_SCRATCH_0}
        |=> regs[ADDR_SCRATCH_0] == $past(core_req.wdata))
        else $error("data-space alias write lost");
    AST_FLAG_SET_WINS: assert property (
        core_req.valid && core_req.op == OP_WRITE && in_map && hw_set(idx, periph_in) != 8'h00
        |=> (sel_now & h_hw) == h_hw)
        else $error("flag event lost to a clear");
    AST_UNMAPPED_READ_ZERO: assert property (
        core_req.valid && core_req.op == OP_READ && !in_map
        |=> core_rsp.done && core_rsp.rdata == 8'h00 && !core_rsp.refused)
        else $error("unmapped read returned data");
    AST_SKIP_ONLY_TEST: assert property (
        !(core_req.valid && test_op) |=> !core_rsp.skip)
        else $error("skip without a bit test");

    COV_SET_BIT: cover property (
        core_req.valid && core_req.op == OP_SET_SINGLE_IO_BIT && bit_ok);
    COV_SKIP_TAKEN: cover property (core_rsp.skip);
    COV_FLAG_CLEAR: cover property (
        core_req.valid && core_req.op == OP_WRITE && (wd & w1c_mask(idx)) != 8'h00);
    COV_DATA_SPACE: cover property (core_req.valid && core_req.data_space && in_map);
    COV_SET_WINS: cover property (
        core_req.valid && core_req.op == OP_WRITE && (hw_set(idx, periph_in) & wd) != 8'h00);
endmodule

// ### io_space_pkg.sv
package io_space_pkg;
    localparam logic [6:0] DATA_SPACE_OFFSET = 7'h20;
    localparam logic [6:0] BIT_RANGE_TOP = 7'h1f;
    localparam logic [5:0] MAP_LAST = 6'h21;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] FULL_BYTE = 8'hff;
    localparam logic [5:0] ADDR_POWER_REDUCTION = 6'h00;
    localparam logic [5:0] ADDR_INPUT_DISABLE = 6'h01;
    localparam logic [5:0] ADDR_CONV_LOW = 6'h04;
    localparam logic [5:0] ADDR_CONV_HIGH = 6'h05;
    localparam logic [5:0] ADDR_CONV_CONTROL = 6'h06;
    localparam logic [5:0] ADDR_CONV_CHANNEL = 6'h07;
    localparam logic [5:0] ADDR_COMPARATOR = 6'h08;
    localparam logic [5:0] ADDR_TIMER1_FLAGS = 6'h0b;
    localparam logic [5:0] ADDR_TIMER1_MASK = 6'h0c;
    localparam logic [5:0] ADDR_SERIAL_CONTROL = 6'h0d;
    localparam logic [5:0] ADDR_SERIAL_STATUS = 6'h0e;
    localparam logic [5:0] ADDR_SERIAL_DATA = 6'h0f;
    localparam logic [5:0] ADDR_SERIAL_BUFFER = 6'h10;
    localparam logic [5:0] ADDR_PIN_MASK_LOW = 6'h12;
    localparam logic [5:0] ADDR_SCRATCH_0 = 6'h13;
    localparam logic [5:0] ADDR_SCRATCH_1 = 6'h14;
    localparam logic [5:0] ADDR_SCRATCH_2 = 6'h15;
    localparam logic [5:0] ADDR_PORT_B_INPUT = 6'h16;
    localparam logic [5:0] ADDR_PORT_B_DIRECTION = 6'h17;
    localparam logic [5:0] ADDR_PORT_B_OUTPUT = 6'h18;
    localparam logic [5:0] ADDR_PORT_A_INPUT = 6'h19;
    localparam logic [5:0] ADDR_PORT_A_DIRECTION = 6'h1a;
    localparam logic [5:0] ADDR_PORT_A_OUTPUT = 6'h1b;
    localparam logic [5:0] ADDR_NV_CONTROL = 6'h1c;
    localparam logic [5:0] ADDR_NV_VALUE = 6'h1d;
    localparam logic [5:0] ADDR_NV_LOCATION = 6'h1e;
    localparam logic [5:0] ADDR_PIN_MASK_HIGH = 6'h20;
    localparam logic [5:0] ADDR_WATCHDOG = 6'h21;
    localparam logic [7:0] RW_POWER_REDUCTION = 8'hef;
    localparam logic [7:0] RW_INPUT_DISABLE = 8'h3f;
    localparam logic [7:0] RW_CONV_CONTROL = 8'hef;
    localparam logic [7:0] W1C_CONV_CONTROL = 8'h10;
    localparam logic [7:0] RW_CONV_CHANNEL = 8'h47;
    localparam logic [7:0] RW_COMPARATOR = 8'hcb;
    localparam logic [7:0] W1C_COMPARATOR = 8'h10;
    localparam logic [7:0] RO_COMPARATOR = 8'h20;
    localparam logic [7:0] W1C_TIMER1 = 8'h07;
    localparam logic [7:0] RW_TIMER1_MASK = 8'h07;
    localparam logic [7:0] RW_SERIAL_STATUS = 8'h0f;
    localparam logic [7:0] W1C_SERIAL_STATUS = 8'he0;
    localparam logic [7:0] RO_SERIAL_STATUS = 8'h10;
    localparam logic [7:0] RW_NV_CONTROL = 8'h3f;
    localparam logic [7:0] RW_NV_LOCATION = 8'h3f;
    localparam logic [7:0] RW_WATCHDOG = 8'h7f;
    localparam logic [7:0] W1C_WATCHDOG = 8'h80;

    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_WRITE = 3'h1,
        OP_SET_SINGLE_IO_BIT = 3'h2,
        OP_CLEAR_SINGLE_IO_BIT = 3'h3,
        OP_SKIP_IF_IO_BIT_ONE = 3'h4,
        OP_SKIP_IF_IO_BIT_ZERO = 3'h5
    } io_op_t;

    typedef struct packed {
        logic valid;
        io_op_t op;
        logic data_space;
        logic [6:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } core_req_t;

    typedef struct packed {
        logic done;
        logic [7:0] rdata;
        logic skip;
        logic refused;
    } core_rsp_t;

    typedef struct packed {
        logic [7:0] conv_low, conv_high, serial_buffer;
        logic comp_out, serial_collision;
        logic [2:0] timer1_set, serial_set;
        logic conv_done, comp_event, wdog_event;
    } periph_in_t;

    typedef struct packed {
        logic [7:0] power_reduction, digital_input_disable;
        logic [7:0] converter_control_status_a, converter_channel_select;
        logic [7:0] comparator_control_status, timer1_flags, timer1_irq_mask;
        logic [7:0] serial_if_control, serial_if_status, serial_if_shift_data;
        logic [7:0] pin_change_mask_low, pin_change_mask_high;
        logic [7:0] nv_data_control, nv_data_value, nv_data_location;
        logic [7:0] watchdog_control_status;
    } periph_cfg_t;
endpackage

// ### core_model.sv
`timescale 1ns/1ps
module core_model (
    input wire logic clk,
    output io_space_pkg::core_req_t core_req,
    input io_space_pkg::core_rsp_t core_rsp
);
    import io_space_pkg::*;
    initial begin
        core_req = '0;
    end
    // one request per call; response sampled half a cycle after the taking edge
    task automatic io_op(input io_op_t op, input logic ds, input logic [6:0] a,
                         input logic [2:0] b, input logic [7:0] wd, output core_rsp_t rsp);
        logic [6:0] io;
        io = ds ? a - DATA_SPACE_OFFSET : a;
        if (op == OP_WRITE && io inside {7'h02, 7'h09, 7'h0a, 7'h11, 7'h1f, 7'h22}) begin
            op = OP_READ;
        end
        @(negedge clk);
        core_req <= '{valid: 1'b1, op: op, data_space: ds, addr: a, bit_sel: b, wdata: wd};
        @(negedge clk);
        rsp = core_rsp;
        core_req.valid <= 1'b0;
    endtask
endmodule

// ### testbench.sv
`timescale 1ns/1ps
`define CHECK(g, w) begin checks_done++; if ((g) !== (w)) begin err_count++; \
    $display("unexpected %0t: got %h want %h", $time, g, w); end end
module testbench;
    import io_space_pkg::*;
    logic clk;
    logic arst_n;
    core_req_t core_req;
    core_rsp_t core_rsp, rsp;
    periph_in_t periph_in;
    periph_cfg_t periph_cfg;
    logic [7:0] port_a_o, port_a_oe, port_b_o, port_b_oe;
    logic [7:0] port_a_pins, port_b_pins;
    int err_count = 0;
    int checks_done = 0;

    io_register_space_bit_access DUT (
        .clk(clk), .arst_n(arst_n), .core_req(core_req), .core_rsp(core_rsp),
        .periph_in(periph_in), .periph_cfg(periph_cfg),
        .port_a_pins(port_a_pins), .port_b_pins(port_b_pins),
        .port_a_o(port_a_o), .port_a_oe(port_a_oe), .port_b_o(port_b_o), .port_b_oe(port_b_oe)
    );
    core_model core (.clk(clk), .core_req(core_req), .core_rsp(core_rsp));

    task automatic do_op(io_op_t op, logic ds, logic [6:0] a, logic [2:0] b, logic [7:0] wd);
        core.io_op(op, ds, a, b, wd, rsp);
        `CHECK(rsp.done, 1'b1)
    endtask
    task automatic wr(logic ds, logic [6:0] a, logic [7:0] d);
        do_op(OP_WRITE, ds, a, 3'h0, d);
    endtask
    task automatic rd_chk(logic ds, logic [6:0] a, logic [7:0] exp);
        do_op(OP_READ, ds, a, 3'h0, 8'h00);
        `CHECK(rsp.rdata, exp)
    endtask

    task automatic t_alias;
        wr(1'b1, 7'h33, 8'h5a);
        rd_chk(1'b1, 7'h33, 8'h5a);
        rd_chk(1'b0, 7'h13, 8'h5a);
        wr(1'b1, 7'h41, 8'h0f);
        rd_chk(1'b0, 7'h21, 8'h0f);
        rd_chk(1'b1, 7'h36, 8'h69);
        rd_chk(1'b1, 7'h13, 8'h00);
    endtask

    task automatic t_bits;
        rd_chk(1'b0, 7'h15, 8'h00);
        for (int i = 0; i < 8; i++) begin
            do_op(OP_SET_SINGLE_IO_BIT, 1'b0, 7'h15, 3'(i), 8'h00);
            rd_chk(1'b0, 7'h15, 8'((2 << i) - 1));
        end
        do_op(OP_CLEAR_SINGLE_IO_BIT, 1'b0, 7'h15, 3'h0, 8'h00);
        rd_chk(1'b0, 7'h15, 8'hfe);
        do_op(OP_SET_SINGLE_IO_BIT, 1'b0, 7'h1b, 3'h7, 8'h00);
        `CHECK(port_a_o, 8'h80)
        wr(1'b0, 7'h1a, 8'hc3);
        do_op(OP_SET_SINGLE_IO_BIT, 1'b0, 7'h17, 3'h2, 8'h00);
        do_op(OP_SET_SINGLE_IO_BIT, 1'b0, 7'h18, 3'h6, 8'h00);
        `CHECK({port_a_oe, port_b_oe, port_b_o}, 24'hc30440)
    endtask

    task automatic t_skip;
        do_op(OP_SKIP_IF_IO_BIT_ONE, 1'b0, 7'h15, 3'h0, 8'h00);
        `CHECK(rsp.skip, 1'b0)
        do_op(OP_SKIP_IF_IO_BIT_ZERO, 1'b0, 7'h15, 3'h0, 8'h00);
        `CHECK(rsp.skip, 1'b1)
        do_op(OP_SKIP_IF_IO_BIT_ONE, 1'b0, 7'h15, 3'h7, 8'h00);
        `CHECK(rsp.skip, 1'b1)
        do_op(OP_SKIP_IF_IO_BIT_ZERO, 1'b0, 7'h15, 3'h7, 8'h00);
        `CHECK(rsp.skip, 1'b0)
    endtask

    task automatic t_flags;
        @(negedge clk);
        periph_in.timer1_set = 3'h7;
        periph_in.serial_set = 3'h7;
        @(negedge clk);
        periph_in = '0;
        rd_chk(1'b0, 7'h0b, 8'h07);
        wr(1'b0, 7'h0b, 8'h00);
        rd_chk(1'b0, 7'h0b, 8'h07);
        wr(1'b0, 7'h0b, 8'h01);
        rd_chk(1'b0, 7'h0b, 8'h06);
        do_op(OP_SET_SINGLE_IO_BIT, 1'b0, 7'h0b, 3'h1, 8'h00);
        do_op(OP_CLEAR_SINGLE_IO_BIT, 1'b0, 7'h0b, 3'h2, 8'h00);
        `CHECK(periph_cfg.timer1_flags, 8'h04)
        do_op(OP_SET_SINGLE_IO_BIT, 1'b0, 7'h0e, 3'h0, 8'h00);
        rd_chk(1'b0, 7'h0e, 8'he1);
    endtask

    task automatic t_range;
        do_op(OP_SET_SINGLE_IO_BIT, 1'b0, 7'h20, 3'h0, 8'h00);
        `CHECK(rsp.refused, 1'b1)
        do_op(OP_SKIP_IF_IO_BIT_ZERO, 1'b1, 7'h41, 3'h6, 8'h00);
        `CHECK({rsp.refused, rsp.skip}, 2'b10)
        rd_chk(1'b0, 7'h20, 8'h00);
        wr(1'b0, 7'h20, 8'h3c);
        rd_chk(1'b0, 7'h20, 8'h3c);
        do_op(OP_SET_SINGLE_IO_BIT, 1'b0, 7'h1e, 3'h5, 8'h00);
        `CHECK({rsp.refused, periph_cfg.nv_data_location}, 9'h020)
    endtask

    task automatic t_events;
        @(negedge clk);
        port_a_pins = 8'h3c;
        periph_in.conv_low = 8'h12;
        periph_in.conv_high = 8'h03;
        periph_in.serial_buffer = 8'ha5;
        periph_in.comp_out = 1'b1;
        periph_in.serial_collision = 1'b1;
        periph_in.conv_done = 1'b1;
        periph_in.comp_event = 1'b1;
        @(negedge clk);
        periph_in.conv_done = 1'b0;
        periph_in.comp_event = 1'b0;
        rd_chk(1'b1, 7'h39, 8'h96);
        rd_chk(1'b1, 7'h24, 8'h12);
        rd_chk(1'b1, 7'h25, 8'h03);
        rd_chk(1'b1, 7'h30, 8'ha5);
        rd_chk(1'b0, 7'h19, 8'h3c);
        rd_chk(1'b0, 7'h06, 8'h10);
        rd_chk(1'b0, 7'h08, 8'h30);
        rd_chk(1'b0, 7'h0e, 8'hf1);
        do_op(OP_CLEAR_SINGLE_IO_BIT, 1'b0, 7'h08, 3'h4, 8'h00);
        rd_chk(1'b0, 7'h08, 8'h30);
        do_op(OP_SET_SINGLE_IO_BIT, 1'b0, 7'h06, 3'h4, 8'h00);
        rd_chk(1'b0, 7'h06, 8'h00);
        fork
            wr(1'b0, 7'h21, 8'h80);
            begin
                @(negedge clk);
                periph_in.wdog_event = 1'b1;
                @(negedge clk);
                periph_in.wdog_event = 1'b0;
            end
        join
        rd_chk(1'b0, 7'h21, 8'h80);
        wr(1'b0, 7'h21, 8'h80);
        rd_chk(1'b0, 7'h21, 8'h00);
    endtask

    task automatic stop_test;
        if (err_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // a hung handshake would otherwise stall the run forever
    initial begin
        repeat (2000) @(posedge clk);
        err_count++;
        stop_test;
    end

    initial begin
        arst_n = 1'b0;
        periph_in = '0;
        port_a_pins = 8'h96;
        port_b_pins = 8'h69;
        repeat (4) @(negedge clk);
        arst_n = 1'b1;
        t_alias;
        t_bits;
        t_skip;
        t_flags;
        t_range;
        t_events;
        stop_test;
    end
endmodule
